/* src/hwt_pkg.sv */
// shared constants and types of the hibernation wake timer
package hwt_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] HWT_OFS_RELOAD = 12'h000;
  localparam logic [11:0] HWT_OFS_CONTROL = 12'h004;
  localparam logic [11:0] HWT_OFS_COUNT = 12'h008;
  localparam logic [11:0] HWT_OFS_STATUS = 12'h00C;
  localparam logic [11:0] HWT_OFS_MASK = 12'h010;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int HWT_CNT_W = 16;
  localparam int HWT_CTRL_RES_BIT = 0;
  localparam int HWT_STAT_ZERO_BIT = 0;
  localparam logic [15:0] HWT_RELOAD_RST = 16'h0000;
  localparam logic [15:0] HWT_COUNT_RST = 16'h0000;
  localparam logic HWT_COARSE_RST = 1'b0;
  localparam logic HWT_STATUS_RST = 1'b0;
  localparam logic HWT_MASK_RST = 1'b0;

  // ****************************************
  // timing
  // ****************************************
  localparam int HWT_SLOW_CLK_HZ = 32768;
  localparam int HWT_COARSE_PERIOD_MS = 125;
  localparam int HWT_COARSE_DIV = HWT_SLOW_CLK_HZ * HWT_COARSE_PERIOD_MS / 1000;
  localparam int HWT_PRESC_W = $clog2(HWT_COARSE_DIV);
  localparam logic [HWT_PRESC_W-1:0] HWT_PRESC_LAST = HWT_PRESC_W'(HWT_COARSE_DIV - 1);

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } hwt_apb_req_t;

  typedef struct packed {
    logic [2:0] sync;
    logic slow_level;
    logic [15:0] count;
    logic [15:0] reload;
    logic coarse;
    logic running;
    logic [HWT_PRESC_W-1:0] presc;
    logic status;
    logic mask;
    logic [31:0] prdata;
  } hwt_state_t;

endpackage

/* src/hwt_wake_timer.sv */
// hibernation wake timer with apb register slave
`timescale 1ns/100ps

module hwt_wake_timer
  import hwt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire hwt_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clk_32k,
  input wire logic [1:0] sleep_en,
  output logic clk_required,
  output logic wake_timer_irq
);

  // ****************************************
  // state
  // ****************************************
  hwt_state_t st;
  hwt_state_t next_st;

  logic setup;
  logic wr_acc;
  logic rd_setup;
  logic slow_tick;
  logic step;
  logic reload_wr;
  logic hit_zero;
  logic known_addr;

  // ****************************************
  // apb decode
  // ****************************************
  // zero wait states: read data is captured in the setup cycle
  assign setup = apb_req.psel & ~apb_req.penable;
  assign rd_setup = setup & ~apb_req.pwrite;
  assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign pready = apb_req.psel & apb_req.penable;
  assign prdata = st.prdata;

  always_comb begin
    case (apb_req.paddr)
      HWT_OFS_RELOAD,
      HWT_OFS_CONTROL,
      HWT_OFS_COUNT,
      HWT_OFS_STATUS,
      HWT_OFS_MASK: begin
        known_addr = 1'b1;
      end
      default: begin
        known_addr = 1'b0;
      end
    endcase
  end

  // unmapped addresses answer with an error, nothing stored
  assign pslverr = pready & ~known_addr;

  // clock request window
  // the core also updates on slow edges outside any access; the request follows psel alone
  assign clk_required = apb_req.psel;

  // sleep ignored
  // sleep_en is deliberately left unread; counting goes on regardless

  // ****************************************
  // slow clock sampling and prescaler
  // ****************************************
  // slow clock only
  // slow edge detect
  // a rising slow edge counts once the second and third stages agree
  assign slow_tick = (st.sync[1] == st.sync[2]) & st.sync[1] & ~st.slow_level;

  assign step = slow_tick & (~st.coarse | (st.presc == HWT_PRESC_LAST));

  assign reload_wr = wr_acc & (apb_req.paddr == HWT_OFS_RELOAD);

  assign hit_zero = st.running & step & (st.count == 16'h0001) & ~reload_wr;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    // first stage feeds only the second
    next_st.sync = {st.sync[1], st.sync[0], clk_32k};
    if (st.sync[1] == st.sync[2]) begin
      next_st.slow_level = st.sync[1];
    end

    if (slow_tick) begin
      if (st.coarse) begin
        next_st.presc = st.presc + 1'b1;
      end else begin
        next_st.presc = '0;
      end
    end

    if (st.running && step) begin
      next_st.count = st.count - 16'h0001;
    end

    if (hit_zero) begin
      next_st.running = 1'b0;
    end

    if (wr_acc && known_addr) begin
      case (apb_req.paddr)
        HWT_OFS_RELOAD: begin
          next_st.reload = apb_req.pwdata[15:0];
          if (apb_req.pwdata[15:0] != 16'h0000) begin
            next_st.count = apb_req.pwdata[15:0];
            next_st.running = 1'b1;
            next_st.presc = '0;
          end else begin
            next_st.running = 1'b0;
          end
        end
        HWT_OFS_CONTROL: begin
          next_st.coarse = apb_req.pwdata[HWT_CTRL_RES_BIT];
        end
        HWT_OFS_STATUS: begin
          if (apb_req.pwdata[HWT_STAT_ZERO_BIT]) begin
            next_st.status = 1'b0;
          end
        end
        HWT_OFS_MASK: begin
          next_st.mask = apb_req.pwdata[HWT_STAT_ZERO_BIT];
        end
        default: begin
          next_st.mask = st.mask;
        end
      endcase
    end

    // set wins over a same-cycle clear
    if (hit_zero) begin
      next_st.status = 1'b1;
    end

    if (rd_setup) begin
      case (apb_req.paddr)
        HWT_OFS_RELOAD: next_st.prdata = {16'h0000, st.reload};
        HWT_OFS_CONTROL: next_st.prdata = {31'h00000000, st.coarse};
        HWT_OFS_COUNT: next_st.prdata = {16'h0000, st.count};
        HWT_OFS_STATUS: next_st.prdata = {31'h00000000, st.status};
        HWT_OFS_MASK: next_st.prdata = {31'h00000000, st.mask};
        default: next_st.prdata = 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // full reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.sync <= 3'h0;
      st.slow_level <= 1'b0;
      st.count <= HWT_COUNT_RST;
      st.reload <= HWT_RELOAD_RST;
      st.coarse <= HWT_COARSE_RST;
      st.running <= 1'b0;
      st.presc <= '0;
      st.status <= HWT_STATUS_RST;
      st.mask <= HWT_MASK_RST;
      st.prdata <= 32'h00000000;
    end else begin
      st <= next_st;
    end
  end

  // interrupt and wake output
  // one level serves as both interrupt and wake request
  assign wake_timer_irq = st.status & st.mask;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_reload_nz;
    wr_acc && apb_req.paddr == HWT_OFS_RELOAD && apb_req.pwdata[15:0] != 16'h0000;
  endsequence

  sequence s_last_step;
    st.running && step && st.count == 16'h0001 && !reload_wr;
  endsequence

  property p_reset_default;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (st.count == 16'h0000 && !st.running && !st.status && !st.coarse);
  endproperty
  a_reset_default: assert property (p_reset_default) else $error("reset state wrong");

  property p_fine_step;
    @(posedge pclk) disable iff (!presetn)
      (st.running && slow_tick && !st.coarse && st.count > 16'h0001 && !reload_wr)
        |=> (st.count == $past(st.count) - 16'h0001);
  endproperty
  a_fine_step: assert property (p_fine_step) else $error("fine tick did not decrement");

  property p_coarse_hold;
    @(posedge pclk) disable iff (!presetn)
      (st.running && st.coarse && slow_tick && st.presc != HWT_PRESC_LAST && !reload_wr)
        |=> (st.count == $past(st.count));
  endproperty
  a_coarse_hold: assert property (p_coarse_hold) else $error("coarse count moved early");

  property p_zero_event;
    @(posedge pclk) disable iff (!presetn)
      s_last_step |=> (st.count == 16'h0000 && !st.running && st.status);
  endproperty
  a_zero_event: assert property (p_zero_event) else $error("zero not flagged");

  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
      (s_last_step and st.mask) |=> ##0 wake_timer_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq missing after zero");

  property p_hold_zero;
    @(posedge pclk) disable iff (!presetn)
      (!st.running && st.count == 16'h0000 && !reload_wr) |=> (st.count == 16'h0000);
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("counter left zero on its own");

  property p_load_start;
    @(posedge pclk) disable iff (!presetn)
      s_reload_nz |=> (st.running && st.count == $past(apb_req.pwdata[15:0]));
  endproperty
  a_load_start: assert property (p_load_start) else $error("reload did not start count");

  property p_zero_stops;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && apb_req.paddr == HWT_OFS_RELOAD && apb_req.pwdata[15:0] == 16'h0000)
        |=> (!st.running ##1 !st.status || $past(st.status) || !$past(st.running, 2));
  endproperty
  a_zero_stops: assert property (p_zero_stops) else $error("zero reload did not stop");

  property p_count_read;
    @(posedge pclk) disable iff (!presetn)
      (rd_setup && apb_req.paddr == HWT_OFS_COUNT) |=> (prdata == {16'h0000, $past(st.count)});
  endproperty
  a_count_read: assert property (p_count_read) else $error("count readback wrong");

  property p_clk_required;
    @(posedge pclk) disable iff (!presetn)
      clk_required |-> apb_req.psel;
  endproperty
  a_clk_required: assert property (p_clk_required) else $error("clock request stray");

  // clear strobe of the sticky bit, shared by the sticky and clear checks
  logic stat_clr_wr;
  assign stat_clr_wr = wr_acc & (apb_req.paddr == HWT_OFS_STATUS)
    & apb_req.pwdata[HWT_STAT_ZERO_BIT];

  property p_one_tick;
    @(posedge pclk) disable iff (!presetn)
      slow_tick |=> !slow_tick;
  endproperty
  a_one_tick: assert property (p_one_tick) else $error("slow edge counted twice");

  property p_cnt_idle;
    @(posedge pclk) disable iff (!presetn)
      (!slow_tick && !reload_wr) |=> (st.count == $past(st.count));
  endproperty
  a_cnt_idle: assert property (p_cnt_idle) else $error("count moved without edge");

  property p_coarse_step;
    @(posedge pclk) disable iff (!presetn)
      (st.running && st.coarse && slow_tick && st.presc == HWT_PRESC_LAST && !reload_wr)
        |=> (st.count == $past(st.count) - 16'h0001);
  endproperty
  a_coarse_step: assert property (p_coarse_step) else $error("coarse step missed");

  property p_presc_clear;
    @(posedge pclk) disable iff (!presetn)
      s_reload_nz |=> (st.presc == '0);
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared");

  property p_fine_presc;
    @(posedge pclk) disable iff (!presetn)
      (!st.coarse && slow_tick) |=> (st.presc == '0);
  endproperty
  a_fine_presc: assert property (p_fine_presc) else $error("prescaler ran in fine");

  property p_stat_sticky;
    @(posedge pclk) disable iff (!presetn)
      (st.status && !stat_clr_wr) |=> st.status;
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status lost");

  property p_stat_clear;
    @(posedge pclk) disable iff (!presetn)
      (stat_clr_wr && !hit_zero) |=> !st.status;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");

  property p_idle_quiet;
    @(posedge pclk) disable iff (!presetn)
      (!st.running && !st.status) |=> !st.status;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("event while stopped");

  property p_zero_keeps;
    @(posedge pclk) disable iff (!presetn)
      (reload_wr && apb_req.pwdata[15:0] == 16'h0000 && !step)
        |=> (st.count == $past(st.count));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero reload moved count");

  property p_run_nonzero;
    @(posedge pclk) disable iff (!presetn)
      st.running |-> (st.count != 16'h0000);
  endproperty
  a_run_nonzero: assert property (p_run_nonzero) else $error("running at zero");

  property p_cnt_wr_ign;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && apb_req.paddr == HWT_OFS_COUNT && !step)
        |=> (st.count == $past(st.count));
  endproperty
  a_cnt_wr_ign: assert property (p_cnt_wr_ign) else $error("count write landed");

  property p_read_hold;
    @(posedge pclk) disable iff (!presetn)
      !rd_setup |=> (prdata == $past(prdata));
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data changed");

endmodule

/* dv/tb_top.sv */
// self-checking bench of the hibernation wake timer
`timescale 1ns/100ps

module tb_top;
  import hwt_pkg::*;
  logic pclk, presetn, clk_32k, pready, pslverr, clk_required, wake_timer_irq;
  logic [1:0] sleep_en;
  logic [31:0] prdata, rdat;
  logic last_err, last_crq;
  hwt_apb_req_t apb_req;
  int mismatches, cmp_count;
  logic [11:0] ofs [5];

  hwt_wake_timer hwt_wake_timer_i (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .clk_32k(clk_32k),
    .sleep_en(sleep_en),
    .clk_required(clk_required),
    .wake_timer_irq(wake_timer_irq)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ****
  // access tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // waits for pready as long as it takes; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h1, "access cycles");
    rdat = prdata;
    last_err = pslverr;
    last_crq = clk_required;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string w);
    apb(1'b0, a, 32'h0);
    chk(rdat, e, w);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // slow edges spaced well beyond the 3-flop synchroniser delay
  task automatic tick(input int n);
    repeat (n) begin
      clk_32k <= 1'b1;
      repeat (5) @(posedge pclk);
      clk_32k <= 1'b0;
      sleep_en <= ~sleep_en;
      repeat (5) @(posedge pclk);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ****
  // tests
  // ****
  initial begin
    presetn = 1'b0;
    clk_32k = 1'b0;
    sleep_en = 2'b00;
    apb_req = '0;
    mismatches = 0;
    cmp_count = 0;
    ofs = '{HWT_OFS_RELOAD, HWT_OFS_CONTROL, HWT_OFS_COUNT, HWT_OFS_STATUS, HWT_OFS_MASK};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 32'h0, "reset value");
    chk(last_crq, 32'h1, "clk req in cycle");
    @(posedge pclk);
    chk(clk_required, 32'h0, "clk req idle");
    rd(12'h014, 32'h0, "unmapped read");
    chk(last_err, 32'h1, "unmapped error");
    wr(HWT_OFS_MASK, 32'h1);
    wr(HWT_OFS_COUNT, 32'h1234);
    rd(HWT_OFS_COUNT, 32'h0, "count write");
    wr(HWT_OFS_RELOAD, 32'h3);
    rd(HWT_OFS_COUNT, 32'h3, "loaded");
    rd(HWT_OFS_RELOAD, 32'h3, "reload rw");
    chk(last_err, 32'h0, "mapped no error");
    // sleep_en toggles all along, must not stall counting
    for (int i = 2; i >= 0; i--) begin
      tick(1);
      rd(HWT_OFS_COUNT, 32'(i), "fine step");
      chk(wake_timer_irq, 32'(i == 0), "irq at zero");
    end
    tick(3);
    rd(HWT_OFS_COUNT, 32'h0, "held at zero");
    wr(HWT_OFS_MASK, 32'h0);
    @(posedge pclk);
    chk(wake_timer_irq, 32'h0, "masked");
    rd(HWT_OFS_STATUS, 32'h1, "status sticky");
    wr(HWT_OFS_STATUS, 32'h1);
    rd(HWT_OFS_STATUS, 32'h0, "status cleared");
    wr(HWT_OFS_MASK, 32'h1);
    wr(HWT_OFS_RELOAD, 32'h5);
    tick(2);
    wr(HWT_OFS_RELOAD, 32'h0);
    tick(4);
    rd(HWT_OFS_COUNT, 32'h3, "stopped");
    chk(wake_timer_irq, 32'h0, "no event");
    // coarse needs 4096 slow edges per step, the longest part of the run
    wr(HWT_OFS_CONTROL, 32'h1);
    rd(HWT_OFS_CONTROL, 32'h1, "res bit");
    wr(HWT_OFS_RELOAD, 32'h2);
    tick(4095);
    rd(HWT_OFS_COUNT, 32'h2, "coarse hold");
    tick(1);
    rd(HWT_OFS_COUNT, 32'h1, "coarse step");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(HWT_OFS_COUNT, 32'h0, "count after reset");
    rd(HWT_OFS_CONTROL, 32'h0, "control after reset");
    final_report();
  end

  // run needs about 41k cycles
  initial begin
    #900000;
    mismatches++;
    final_report();
  end
endmodule
